// File: rtl/sph_pkg.sv
// shared constants and types for the stepper pulse link
package sph_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DIR_SETTLE_NS   = 10000;  // least wait after a direction change
  localparam int DIR_SETTLE_CYC  = (DIR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_HI_CYC    = 4;      // conducting part of a host pulse
  localparam int PULSE_LO_CYC    = 4;      // non-conducting gap after a pulse
  localparam int RELEASE_WAIT_CYC = 1000;  // host pause after winding release ends
  localparam int CNT_W           = 16;

  // position counter
  localparam int POS_W = 12;
  localparam logic [POS_W-1:0] POS_HOME = 12'h000;

  // reset values
  localparam logic RST_LINE_OFF = 1'b0;    // photocoupler not conducting
  localparam logic RST_SEL_A    = 1'b0;    // first step setting

  // pulse input modes on the mode switch
  typedef enum logic {SPH_MODE_ONE = 1'b0, SPH_MODE_TWO = 1'b1} sph_mode_t;

  // microsteps in ten base steps for each division code
  function automatic logic [POS_W-1:0] ten_step_count(input logic [3:0] code);
    logic [POS_W-1:0] n;
    n = 12'h00a;
    unique case (code)
      4'h0: n = 12'h00a;  // 10
      4'h1: n = 12'h014;  // 20
      4'h2: n = 12'h019;  // 25
      4'h3: n = 12'h028;  // 40
      4'h4: n = 12'h032;  // 50
      4'h5: n = 12'h050;  // 80
      4'h6: n = 12'h064;  // 100
      4'h7: n = 12'h0c8;  // 200
      4'h8: n = 12'h0fa;  // 250
      4'h9: n = 12'h190;  // 400
      4'ha: n = 12'h1f4;  // 500
      4'hb: n = 12'h320;  // 800
      4'hc: n = 12'h3e8;  // 1000
      4'hd: n = 12'h4e2;  // 1250
      4'he: n = 12'h7d0;  // 2000
      4'hf: n = 12'h9c4;  // 2500
    endcase
    return n;
  endfunction

endpackage

// File: rtl/sph_link_if.sv
// wires between the pulse controller and the drive logic
`timescale 1ns/1ps
`default_nettype none
interface sph_link_if;
  logic step_a;       // step_pulse_in in one-pulse mode, cw pulse in two-pulse mode
  logic step_b;       // direction in one-pulse mode, ccw pulse in two-pulse mode
  logic release_w;    // winding release, 1 = conducting
  logic res_sel;      // step setting select, 1 = conducting
  logic timing_o;     // open-collector data, always low
  logic timing_oe_n;  // low while the output transistor conducts
  wire  timing_on;    // home-phase status as the host sees it

  // the transistor pulls the line when enabled
  assign timing_on = ~timing_oe_n;

  modport drv (input step_a, input step_b, input release_w, input res_sel,
               output timing_o, output timing_oe_n);
  modport ctl (output step_a, output step_b, output release_w, output res_sel,
               input timing_on);
endinterface
`default_nettype wire

// File: rtl/sph_drive.sv
// excitation position logic of the stepping drive, with home-phase output
//
// Operation
// RULE1 - one-pulse, direction on: fall steps clockwise
// RULE2 - one-pulse, direction off: fall steps counter-clockwise
// RULE3 - two-pulse: cw input fall steps clockwise
// RULE4 - two-pulse: ccw input fall steps counter-clockwise
// RULE5 - controller never pulses both inputs together
// RULE6 - idle pulse inputs stay non-conducting
// RULE7 - controller waits 10 us after direction change
// RULE8 - release input conducting cuts winding current
// RULE9 - release input off restores winding current
// RULE10 - controller avoids pulses right after release
// RULE11 - select conducting uses second setting
// RULE12 - select input sampled at power-up
// RULE13 - select changes only stopped at home
// RULE14 - home output active at step zero
// RULE15 - power-up puts position at home
// RULE16 - home output recurs every ten base steps
// RULE17 - status output is open-collector switch
// RULE18 - mode switch picks one- or two-pulse inputs
// RULE19 - two settings hold independent division codes
// RULE20 - position counts microsteps, wraps both ways
`timescale 1ns/1ps
`default_nettype none
module sph_drive #(
  parameter int POS_W = sph_pkg::POS_W
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // link to the pulse controller
  sph_link_if.drv               lnk,
  // front-panel settings
  input  wire logic             pulse_mode_switch,
  input  wire logic [3:0]       step_setting_a,
  input  wire logic [3:0]       step_setting_b,
  // drive stage and status
  output logic                  windings_on,
  output logic [POS_W-1:0]      position,
  output logic [POS_W-1:0]      modulus,
  output logic                  step_cw_pulse,
  output logic                  step_ccw_pulse,
  output logic                  setting_b_active,
  output logic                  pulse_conflict
);

  // state registers
  logic             prev_a_r;
  logic             prev_b_r;
  logic             mode_r;
  logic             booted_r;
  logic             sel_r;
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic             windings_r;
  logic             cw_r;
  logic             ccw_r;
  logic             conflict_r;
  logic             oe_n_r;
  logic             tim_o_r;

  // edge and direction decode
  wire logic fall_a;
  wire logic fall_b;
  wire logic mode_two;
  wire logic want_cw;
  wire logic want_ccw;
  wire logic move_cw;
  wire logic move_ccw;
  wire logic both_on;

  // modulus and selection decode
  wire logic [3:0]       code_sel;
  wire logic [POS_W-1:0] mod_now;
  wire logic [POS_W-1:0] mod_last;
  wire logic             at_home;
  wire logic             sel_take;

  // falls from conducting to non-conducting are the only step events
  assign fall_a   = prev_a_r & ~lnk.step_a;
  assign fall_b   = prev_b_r & ~lnk.step_b;
  assign mode_two = (mode_r == sph_pkg::SPH_MODE_TWO);            // see RULE18

  // one-pulse: direction level picks the sense of each fall
  // two-pulse: each input owns one direction
  assign want_cw  = mode_two ? fall_a                             // see RULE3
                             : (fall_a & lnk.step_b);             // see RULE1
  assign want_ccw = mode_two ? fall_b                             // see RULE4
                             : (fall_a & ~lnk.step_b);            // see RULE2

  // coincident falls in two-pulse mode cancel out, no net motion
  assign move_cw  = want_cw & ~want_ccw;
  assign move_ccw = want_ccw & ~want_cw;
  assign both_on  = mode_two & lnk.step_a & lnk.step_b;

  // the active setting chooses the division code and thus the modulus
  assign code_sel = sel_r ? step_setting_b : step_setting_a;      // see RULE11 see RULE19
  assign mod_now  = sph_pkg::ten_step_count(code_sel);            // see RULE20
  assign mod_last = mod_now - 12'h001;
  assign at_home  = (pos_r == sph_pkg::POS_HOME);

  // a new select level is only taken at home with no step this cycle,
  // so the home phase of the old and new modulus coincide
  assign sel_take = at_home & ~move_cw & ~move_ccw;

  // wrap-around position update in microsteps
  always_comb begin
    pos_nxt = pos_r;
    if (move_cw) begin
      pos_nxt = (pos_r >= mod_last) ? sph_pkg::POS_HOME : pos_r + 12'h001;  // see RULE20
    end else if (move_ccw) begin
      pos_nxt = at_home ? mod_last : pos_r - 12'h001;                        // see RULE20
    end else if (pos_r > mod_last) begin
      pos_nxt = sph_pkg::POS_HOME;  // guard against a setting change away from home
    end
  end

  // input edge history and mode switch sampling
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_a_r <= sph_pkg::RST_LINE_OFF;
      prev_b_r <= sph_pkg::RST_LINE_OFF;
      mode_r   <= 1'b0;
    end else begin
      prev_a_r <= lnk.step_a;
      prev_b_r <= lnk.step_b;
      mode_r   <= pulse_mode_switch;
    end
  end

  // setting select: caught at the first edge after power-up, then at home only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      booted_r <= 1'b0;
      sel_r    <= sph_pkg::RST_SEL_A;
    end else begin
      booted_r <= 1'b1;
      if (!booted_r || sel_take) begin
        sel_r <= lnk.res_sel;  // see RULE12 see RULE11
      end
    end
  end

  // excitation position, home after power-up
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pos_r <= sph_pkg::POS_HOME;  // see RULE15
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // winding current follows the release input directly
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      windings_r <= 1'b0;
    end else begin
      windings_r <= ~lnk.release_w;  // see RULE8 see RULE9
    end
  end

  // step event pulses and the two-pulse conflict flag
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cw_r       <= 1'b0;
      ccw_r      <= 1'b0;
      conflict_r <= 1'b0;
    end else begin
      cw_r       <= move_cw;
      ccw_r      <= move_ccw;
      conflict_r <= both_on;  // level while both pulse inputs conduct
    end
  end

  // home-phase status: transistor conducts when the position is zero;
  // with a modulus of ten base steps this recurs every ten base steps
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oe_n_r  <= 1'b1;
      tim_o_r <= 1'b0;
    end else begin
      oe_n_r  <= ~(pos_nxt == sph_pkg::POS_HOME);  // see RULE14 see RULE16 see RULE17
      tim_o_r <= 1'b0;                             // open collector only ever sinks
    end
  end

  // outputs straight from flip-flops
  assign lnk.timing_oe_n  = oe_n_r;
  assign lnk.timing_o     = tim_o_r;
  assign windings_on      = windings_r;
  assign position         = pos_r;
  assign step_cw_pulse    = cw_r;
  assign step_ccw_pulse   = ccw_r;
  assign setting_b_active = sel_r;
  assign pulse_conflict   = conflict_r;

  // modulus is shown registered so software sees a steady figure
  logic [POS_W-1:0] mod_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mod_r <= 12'h000;
    end else begin
      mod_r <= mod_now;
    end
  end
  assign modulus = mod_r;

endmodule
`default_nettype wire

// File: rtl/sph_ctrl.sv
// pulse-train controller end: turns step commands into link pulses
`timescale 1ns/1ps
`default_nettype none
module sph_ctrl #(
  parameter int SETTLE_CYC  = sph_pkg::DIR_SETTLE_CYC,
  parameter int RELEASE_CYC = sph_pkg::RELEASE_WAIT_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // link to the drive
  sph_link_if.ctl   lnk,
  // user commands
  input  wire logic pulse_mode_switch,
  input  wire logic cmd_valid,
  input  wire logic cmd_cw,
  output logic      cmd_ready,
  input  wire logic release_req,
  input  wire logic res_sel_req,
  // status
  output logic      at_home
);

  typedef enum logic [1:0] {SPH_IDLE, SPH_SETTLE, SPH_HIGH, SPH_LOW} sph_hstate_t;

  sph_hstate_t                   st_r;
  logic [sph_pkg::CNT_W-1:0]     cnt_r;
  logic                          dir_r;
  logic                          dir_known_r;
  logic                          a_r;
  logic                          b_r;
  logic                          rel_r;
  logic                          sel_r;
  logic                          ready_r;
  logic                          home_r;

  // command acceptance and direction change detect
  wire logic accept;
  wire logic dir_change;
  wire logic cnt_zero;
  assign accept     = (st_r == SPH_IDLE) & ready_r & cmd_valid;
  assign dir_change = ~dir_known_r | (dir_r != cmd_cw);
  assign cnt_zero   = (cnt_r == '0);

  // pulse sequencer; a direction change waits the settle time first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r        <= SPH_IDLE;
      cnt_r       <= '0;
      dir_r       <= 1'b0;
      dir_known_r <= 1'b0;
    end else begin
      unique case (st_r)
        SPH_IDLE: begin
          if (!cnt_zero) begin
            cnt_r <= cnt_r - 1'b1;
          end
          if (accept) begin
            dir_r       <= cmd_cw;
            dir_known_r <= 1'b1;
            st_r        <= dir_change ? SPH_SETTLE : SPH_HIGH;
            cnt_r       <= dir_change ? sph_pkg::CNT_W'(SETTLE_CYC - 1) : sph_pkg::CNT_W'(sph_pkg::PULSE_HI_CYC - 1);
          end else if (rel_r) begin
            cnt_r <= sph_pkg::CNT_W'(RELEASE_CYC);  // hold off pulses after release
          end
        end
        SPH_SETTLE: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_zero) begin
            st_r  <= SPH_HIGH;
            cnt_r <= sph_pkg::CNT_W'(sph_pkg::PULSE_HI_CYC - 1);
          end
        end
        SPH_HIGH: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_zero) begin
            st_r  <= SPH_LOW;
            cnt_r <= sph_pkg::CNT_W'(sph_pkg::PULSE_LO_CYC - 1);
          end
        end
        SPH_LOW: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_zero) begin
            st_r  <= SPH_IDLE;
            cnt_r <= '0;  // no wrap, so ready returns one cycle after the gap
          end
        end
      endcase
    end
  end

  // link drive: pulse lines idle non-conducting, only one pulse line ever active
  wire logic pulse_on;
  wire logic two;
  assign pulse_on = (st_r == SPH_HIGH);
  assign two      = (pulse_mode_switch == sph_pkg::SPH_MODE_TWO);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      a_r     <= sph_pkg::RST_LINE_OFF;
      b_r     <= sph_pkg::RST_LINE_OFF;
      rel_r   <= 1'b0;
      sel_r   <= sph_pkg::RST_SEL_A;
      ready_r <= 1'b0;
      home_r  <= 1'b0;
    end else begin
      a_r     <= two ? (pulse_on & dir_r) : pulse_on;                  // see RULE6
      b_r     <= two ? (pulse_on & ~dir_r) : (accept ? cmd_cw : dir_r); // see RULE5 see RULE7
      rel_r   <= release_req;
      ready_r <= (st_r == SPH_IDLE) & ~accept & ~rel_r & cnt_zero;     // see RULE10
      home_r  <= lnk.timing_on;
      if ((st_r == SPH_IDLE) && !accept && lnk.timing_on) begin
        sel_r <= res_sel_req;                                          // see RULE13
      end
    end
  end

  assign lnk.step_a    = a_r;
  assign lnk.step_b    = b_r;
  assign lnk.release_w = rel_r;
  assign lnk.res_sel   = sel_r;
  assign cmd_ready     = ready_r;
  assign at_home       = home_r;

endmodule
`default_nettype wire

// File: test/sph_link_chk.sv
// checker on the link wires between controller and drive
`timescale 1ns/1ps
`default_nettype none
module sph_link_chk #(
  parameter int SETTLE_CYC  = sph_pkg::DIR_SETTLE_CYC,
  parameter int RELEASE_CYC = sph_pkg::RELEASE_WAIT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // watched wires
  input wire logic pulse_mode_switch,
  input wire logic step_a,
  input wire logic step_b,
  input wire logic release_w,
  input wire logic timing_o,
  input wire logic timing_oe_n,
  input wire logic timing_on
);
  logic [15:0] dir_gap_r;
  logic [15:0] rel_gap_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // quiet cycles since the direction line moved and since release ended; saturate, never wrap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dir_gap_r <= 16'h0000;
      rel_gap_r <= 16'hffff;
    end else begin
      dir_gap_r <= $changed(step_b) ? 16'h0000 : dir_gap_r + {15'h0000, dir_gap_r != 16'hffff};
      rel_gap_r <= release_w ? 16'h0000 : rel_gap_r + {15'h0000, rel_gap_r != 16'hffff};
    end
  end

  // a host pulse: four cycles on, then at least four off
  sequence s_pulse(s);
    s [*4] ##1 (!s) [*4];
  endsequence
  sequence s_off_home;
    ##[1:2] timing_oe_n;
  endsequence

  // output stage, spacing and home-phase checks
  AST_OC_DATA: assert property (timing_o == 1'b0) else $error("status data not low");
  AST_OC_WIRE: assert property (timing_on == !timing_oe_n) else $error("status wire wrong");
  AST_NO_BOTH: assert property (pulse_mode_switch |-> !(step_a && step_b)) else $error("both pulses on");
  AST_CW_PULSE: assert property ($rose(step_a) |-> s_pulse(step_a)) else $error("step pulse shape");
  AST_CCW_PULSE: assert property ((pulse_mode_switch && $rose(step_b)) |-> s_pulse(step_b)) else $error("ccw shape");
  AST_DIR_WAIT: assert property ((!pulse_mode_switch && $rose(step_a)) |-> dir_gap_r >= SETTLE_CYC)
    else $error("pulse too soon after direction change");
  AST_REL_WAIT: assert property (($rose(step_a) || (pulse_mode_switch && $rose(step_b))) |-> rel_gap_r >= RELEASE_CYC)
    else $error("pulse too soon after release");
  AST_HOME_RESET: assert property ($rose(reset_n) |=> !timing_oe_n) else $error("not home after reset");
  AST_HOME_LEAVE: assert property ((($fell(step_a) || (pulse_mode_switch && $fell(step_b))) && !timing_oe_n)
    |-> s_off_home) else $error("home kept after a step");
endmodule
`default_nettype wire

// File: test/stepper_pulse_input_and_phase_home_tb.sv
// bench: controller end and drive end joined by the link, user sides driven
`timescale 1ns/1ps
`default_nettype none
module stepper_pulse_input_and_phase_home_tb;
  logic                      mclk, reset_n, mode, cmd_valid, cmd_cw, release_req, res_sel_req;
  logic                      cmd_ready, at_home, windings_on, sel_b, cw_p, ccw_p, conflict;
  logic [3:0]                set_a, set_b;
  logic [sph_pkg::POS_W-1:0] position, modulus;
  int                        seed, miscompares, n_compared, exp_pos, m, i, j, n_cw, n_ccw, n_conf;
  int                        mtab [16] = '{10, 20, 25, 40, 50, 80, 100, 200, 250, 400, 500, 800, 1000, 1250, 2000, 2500};

  sph_link_if lnk ();
  sph_drive sph_drive_inst (.mclk(mclk), .reset_n(reset_n), .lnk(lnk), .pulse_mode_switch(mode),
    .step_setting_a(set_a), .step_setting_b(set_b), .windings_on(windings_on), .position(position),
    .modulus(modulus), .step_cw_pulse(cw_p), .step_ccw_pulse(ccw_p), .setting_b_active(sel_b),
    .pulse_conflict(conflict));
  // short settle counts keep the run brief
  sph_ctrl #(.SETTLE_CYC(4), .RELEASE_CYC(4)) sph_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .lnk(lnk),
    .pulse_mode_switch(mode), .cmd_valid(cmd_valid), .cmd_cw(cmd_cw), .cmd_ready(cmd_ready),
    .release_req(release_req), .res_sel_req(res_sel_req), .at_home(at_home));
  sph_link_chk #(.SETTLE_CYC(4), .RELEASE_CYC(4)) chk_inst (.mclk(mclk), .reset_n(reset_n),
    .pulse_mode_switch(mode), .step_a(lnk.step_a), .step_b(lnk.step_b), .release_w(lnk.release_w),
    .timing_o(lnk.timing_o), .timing_oe_n(lnk.timing_oe_n), .timing_on(lnk.timing_on));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // count drive step pulses and conflict cycles; each command looks at its own delta
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      n_cw   <= 0;
      n_ccw  <= 0;
      n_conf <= 0;
    end else begin
      n_cw   <= n_cw + int'(cw_p);
      n_ccw  <= n_ccw + int'(ccw_p);
      n_conf <= n_conf + int'(conflict);
    end
  end

  task automatic test_done();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // bounded wait for the controller to take a command
  task automatic wait_rdy();
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 4000) begin
      miscompares++;
      test_done();
    end
  endtask

  // one step; expected position wraps both ways at the modulus
  task automatic do_cmd(input logic cw);
    int c0;
    int d0;
    wait_rdy();
    c0        = n_cw;
    d0        = n_ccw;
    cmd_cw    <= cw;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    wait_rdy();
    exp_pos = cw ? (exp_pos + 1) % m : (exp_pos + m - 1) % m;
    chk(position, exp_pos);
    chk_flag(at_home, exp_pos == 0);
    chk(n_cw - c0, {31'h0, cw});
    chk(n_ccw - d0, {31'h0, ~cw});
  endtask

  // walk the short way back to step zero
  task automatic go_home();
    while (exp_pos != 0)
      do_cmd(exp_pos >= m / 2);
  endtask

  task automatic do_reset(input logic md, input logic sel, input logic [3:0] a, input logic [3:0] b);
    reset_n     <= 1'b0;
    mode        <= md;
    res_sel_req <= sel;
    set_a       <= a;
    set_b       <= b;
    tick(16);
    reset_n <= 1'b1;
    tick(6);
    m       = sel ? mtab[b] : mtab[a];
    exp_pos = 0;
    chk(position, 0);
    chk_flag(at_home, 1'b1);
    chk_flag(sel_b, sel);
    chk(modulus, m);
    chk_flag(windings_on, 1'b1);
  endtask

  // main sequence: one-pulse phase with ten microsteps per home cycle, then two-pulse
  initial begin
    seed        = 17;
    reset_n     = 1'b0;
    mode        = 1'b0;
    cmd_valid   = 1'b0;
    cmd_cw      = 1'b0;
    release_req = 1'b0;
    res_sel_req = 1'b0;
    set_a       = 4'h0;
    set_b       = 4'h0;
    miscompares = 0;
    n_compared  = 0;
    for (i = 0; i < 2; i++) begin
      do_reset(i[0], i[0], i ? 4'($random(seed)) : 4'h0, 4'($random(seed)));
      do_cmd(1'b0);
      for (j = 0; j < 11; j++)
        do_cmd(1'b1);
      for (j = 0; j < 30; j++)
        do_cmd(1'($random(seed)));
      // winding release stops current and blocks commands meanwhile
      release_req <= 1'b1;
      tick(4);
      chk_flag(windings_on, 1'b0);
      chk_flag(cmd_ready, 1'b0);
      release_req <= 1'b0;
      tick(4);
      chk_flag(windings_on, 1'b1);
      do_cmd(1'b1);
      // select flips only once back at home
      if (exp_pos == 0)
        do_cmd(1'b1);
      res_sel_req <= ~i[0];
      tick(8);
      chk_flag(sel_b, i[0]);
      go_home();
      tick(8);
      m = i ? mtab[set_a] : mtab[set_b];
      chk_flag(sel_b, ~i[0]);
      chk(modulus, m);
      for (j = 0; j < 12; j++)
        do_cmd(1'($random(seed)));
      chk(n_conf, 0);
    end
    test_done();
  end

  // hang guard
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
